// file: design/bis_cfg.svh
// Constants for the bridge interrupt status block: offsets, bit positions,
// reset values. Included by the package and the design module.
`ifndef BIS_CFG_SVH
`define BIS_CFG_SVH
`define BIS_ADDR_W 12
`define BIS_OFF_STAT 12'h600
`define BIS_OFF_CTL 12'h604
`define BIS_B_PEL 31
`define BIS_B_QEL 30
`define BIS_B_MDPED 29
`define BIS_B_PCSR 28
`define BIS_B_DQE 27
`define BIS_B_DPE 26
`define BIS_B_DRST 25
`define BIS_B_DONE 24
`define BIS_B_PINT 23
`define BIS_B_PERR 22
`define BIS_B_SERR 21
`define BIS_B_QINT 20
`define BIS_B_MB0 16
`define BIS_B_QDPE 15
`define BIS_B_PSC 14
`define BIS_B_OPNE 13
`define BIS_B_IPN 12
`define BIS_B_IFE 11
`define BIS_B_OFE 10
`define BIS_B_IPF 9
`define BIS_B_OFF 8
`define BIS_B_SI0 0
`define BIS_STICKY_MASK 32'hFFFFD00F
`define BIS_LEVEL_MASK 32'h00002F00
`define BIS_CTL_RW_MASK 32'hFFFFDF00
`define BIS_SI_MASK 32'h0000000F
`define BIS_STAT_RST 32'h00000C00
`define BIS_CTL_RST 32'h00000000
`define BIS_ZERO 32'h00000000
`endif

// file: design/bis_interrupt_status.sv
// Interrupt status collection for a PCI to local processor bus bridge.
// Assumes same-clock one-cycle event pulses, same-clock queue levels and
// a plain register port driven from logic on CLK_IN.
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "bis_cfg.svh"
module bis_interrupt_status
  import bis_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [`BIS_ADDR_W-1:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [31:0] RDATA_OUT,
  input wire logic PCI_ERRLOG_IN,
  input wire logic LOCAL_ERRLOG_IN,
  input wire logic MASTER_PARITY_SOURCE_BIT_IN,
  input wire logic PCI_CFG_STATUS_SET_IN,
  input wire logic DMA_LOCAL_ERR_IN,
  input wire logic DMA_PCI_ERR_IN,
  input wire logic DMA_RESET_IN,
  input wire logic DMA_DONE_IN,
  input wire logic PCI_IRQ_IN,
  input wire logic PCI_PARITY_IN,
  input wire logic PCI_SYSERR_IN,
  input wire logic LOCAL_IRQ_IN,
  input wire logic [3:0] MAILBOX_IN,
  input wire logic LOCAL_PARITY_ERR_IN,
  input wire logic POWER_CHANGE_IN,
  input wire logic IN_POST_NEW_IN,
  input wire logic OUT_POST_NONEMPTY_IN,
  input wire logic IN_FREE_EMPTY_IN,
  input wire logic OUT_FREE_EMPTY_IN,
  input wire logic IN_POST_FULL_IN,
  input wire logic OUT_FREE_FULL_IN,
  input wire logic OUT_POST_ENABLE_IN,
  output logic [31:0] ENABLE_OUT,
  output logic IRQ_OUT
);

  // ===========================================================
  // State and event gathering
  bis_state_type st_ff;
  bis_state_type nxt_st;
  logic [31:0] ev;
  logic [31:0] lvl;
  logic [31:0] en_eff;
  logic [31:0] clr;
  logic [31:0] soft_set;
  logic wr_stat;
  logic wr_ctl;
  logic pcs_rise;

  // The source bit is a level; only its rising edge counts as an event.
  assign pcs_rise = MASTER_PARITY_SOURCE_BIT_IN & ~st_ff.pcs_prev_ff;

  // Opaque enable bit for the outbound post list is mirrored from outside.
  always_comb begin
    en_eff = st_ff.enable_ff;
    en_eff[`BIS_B_OPNE] = OUT_POST_ENABLE_IN;
  end

  always_comb begin
    ev = `BIS_ZERO;
    ev[`BIS_B_PEL] = PCI_ERRLOG_IN;
    ev[`BIS_B_QEL] = LOCAL_ERRLOG_IN;
    ev[`BIS_B_MDPED] = pcs_rise;
    ev[`BIS_B_PCSR] = PCI_CFG_STATUS_SET_IN;
    ev[`BIS_B_DQE] = DMA_LOCAL_ERR_IN;
    ev[`BIS_B_DPE] = DMA_PCI_ERR_IN;
    ev[`BIS_B_DRST] = DMA_RESET_IN;
    ev[`BIS_B_DONE] = DMA_DONE_IN;
    ev[`BIS_B_PINT] = PCI_IRQ_IN;
    ev[`BIS_B_PERR] = PCI_PARITY_IN;
    ev[`BIS_B_SERR] = PCI_SYSERR_IN;
    ev[`BIS_B_QINT] = LOCAL_IRQ_IN;
    ev[`BIS_B_MB0+3:`BIS_B_MB0] = MAILBOX_IN;
    ev[`BIS_B_QDPE] = LOCAL_PARITY_ERR_IN;
    ev[`BIS_B_PSC] = POWER_CHANGE_IN;
    ev[`BIS_B_IPN] = IN_POST_NEW_IN;
  end

  // Queue levels follow the queues regardless of any enable.
  always_comb begin
    lvl = `BIS_ZERO;
    lvl[`BIS_B_OPNE] = OUT_POST_NONEMPTY_IN;
    lvl[`BIS_B_IFE] = IN_FREE_EMPTY_IN;
    lvl[`BIS_B_OFE] = OUT_FREE_EMPTY_IN;
    lvl[`BIS_B_IPF] = IN_POST_FULL_IN;
    lvl[`BIS_B_OFF] = OUT_FREE_FULL_IN;
  end

  // ===========================================================
  // Register decode
  assign wr_stat = WR_IN && (ADDR_IN == `BIS_OFF_STAT);
  assign wr_ctl = WR_IN && (ADDR_IN == `BIS_OFF_CTL);
  assign clr = wr_stat ? (WDATA_IN & `BIS_STICKY_MASK) : `BIS_ZERO;
  assign soft_set = wr_ctl ? (WDATA_IN & `BIS_SI_MASK) : `BIS_ZERO;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.pcs_prev_ff = MASTER_PARITY_SOURCE_BIT_IN;
    // Hardware events are gated by their enable before latching; the
    // soft triggers come from software and need no gate. Set beats
    // clear, and a clear touches only this word, never a source bit.
    nxt_st.flags_ff = ((st_ff.flags_ff & ~clr)
                       | (ev & st_ff.enable_ff) | soft_set)
                      & `BIS_STICKY_MASK;
    nxt_st.flags_ff = nxt_st.flags_ff | lvl;
    if (wr_ctl) begin
      nxt_st.enable_ff = WDATA_IN & `BIS_CTL_RW_MASK;
    end
    if (RD_IN) begin
      if (ADDR_IN == `BIS_OFF_STAT) begin
        nxt_st.rdata_ff = st_ff.flags_ff;
      end else if (ADDR_IN == `BIS_OFF_CTL) begin
        // Trigger bits always read zero.
        nxt_st.rdata_ff = en_eff & ~`BIS_SI_MASK;
      end else begin
        nxt_st.rdata_ff = `BIS_ZERO;
      end
    end else begin
      nxt_st.rdata_ff = `BIS_ZERO;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_ff.flags_ff <= `BIS_STAT_RST;
      st_ff.enable_ff <= `BIS_CTL_RST;
      st_ff.rdata_ff <= `BIS_ZERO;
      st_ff.pcs_prev_ff <= 1'h0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign RDATA_OUT = st_ff.rdata_ff;
  assign ENABLE_OUT = en_eff;
  // Level flags count toward the request only when enabled; soft flags
  // are gated by nothing, since their trigger is the software intent.
  assign IRQ_OUT = |(st_ff.flags_ff & (en_eff | `BIS_SI_MASK));

  // ===========================================================
  // Checks
  property p_sticky_hold;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (st_ff.flags_ff[`BIS_B_DONE] && !(wr_stat && WDATA_IN[`BIS_B_DONE]))
    |=> st_ff.flags_ff[`BIS_B_DONE];
  endproperty
  a_sticky_hold: assert property (p_sticky_hold)
    else $error("done flag dropped without a clear");

  property p_set_wins;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (DMA_DONE_IN && st_ff.enable_ff[`BIS_B_DONE] && wr_stat)
    |=> st_ff.flags_ff[`BIS_B_DONE];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost against a clear");

  property p_clear;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (wr_stat && WDATA_IN[`BIS_B_PEL] && !PCI_ERRLOG_IN)
    |=> !st_ff.flags_ff[`BIS_B_PEL];
  endproperty
  a_clear: assert property (p_clear)
    else $error("write one did not clear flag");

  property p_gate;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (!st_ff.enable_ff[`BIS_B_IPN] && !st_ff.flags_ff[`BIS_B_IPN])
    |=> !st_ff.flags_ff[`BIS_B_IPN];
  endproperty
  a_gate: assert property (p_gate)
    else $error("new post flag set while disabled");

  property p_level;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    1'h1 |=> (st_ff.flags_ff[`BIS_B_IFE] == $past(IN_FREE_EMPTY_IN))
      && (st_ff.flags_ff[`BIS_B_OFF] == $past(OUT_FREE_FULL_IN));
  endproperty
  a_level: assert property (p_level)
    else $error("queue level flag out of step");

  property p_soft;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (wr_ctl && WDATA_IN[`BIS_B_SI0]) |=> st_ff.flags_ff[`BIS_B_SI0];
  endproperty
  a_soft: assert property (p_soft)
    else $error("soft trigger did not set flag");

  property p_mdped;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    ($rose(MASTER_PARITY_SOURCE_BIT_IN) && st_ff.enable_ff[`BIS_B_MDPED])
    |=> st_ff.flags_ff[`BIS_B_MDPED];
  endproperty
  a_mdped: assert property (p_mdped)
    else $error("parity seen flag missed");

  property p_irq;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (st_ff.flags_ff[`BIS_B_MB0] && st_ff.enable_ff[`BIS_B_MB0]) |-> IRQ_OUT;
  endproperty
  a_irq: assert property (p_irq)
    else $error("request missing for enabled flag");

  property p_rd;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (RD_IN && ADDR_IN == `BIS_OFF_CTL) |=> (RDATA_OUT[3:0] == 4'h0);
  endproperty
  a_rd: assert property (p_rd)
    else $error("trigger bits read nonzero");

  // ===========================================================
  // Checks on hardware event sources
  // Every source is tied to its own flag bit. A crossed wire between two
  // sources would slip past the shared checks above, so most have their own;
  // DMA_RESET_IN, POWER_CHANGE_IN, MAILBOX_IN[3:1] and the PCI_ERRLOG_IN set have none.
  property p_local_log_set;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (LOCAL_ERRLOG_IN && st_ff.enable_ff[`BIS_B_QEL])
    |=> st_ff.flags_ff[`BIS_B_QEL];
  endproperty
  a_local_log_set: assert property (p_local_log_set)
    else $error("local error log flag missed");

  property p_cfg_status_set;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (PCI_CFG_STATUS_SET_IN && st_ff.enable_ff[`BIS_B_PCSR])
    |=> st_ff.flags_ff[`BIS_B_PCSR];
  endproperty
  a_cfg_status_set: assert property (p_cfg_status_set)
    else $error("config status flag missed");

  property p_dma_local_set;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (DMA_LOCAL_ERR_IN && st_ff.enable_ff[`BIS_B_DQE])
    |=> st_ff.flags_ff[`BIS_B_DQE];
  endproperty
  a_dma_local_set: assert property (p_dma_local_set)
    else $error("dma local error flag missed");

  property p_dma_pci_set;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (DMA_PCI_ERR_IN && st_ff.enable_ff[`BIS_B_DPE])
    |=> st_ff.flags_ff[`BIS_B_DPE];
  endproperty
  a_dma_pci_set: assert property (p_dma_pci_set)
    else $error("dma pci error flag missed");

  property p_pci_irq_set;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (PCI_IRQ_IN && st_ff.enable_ff[`BIS_B_PINT])
    |=> st_ff.flags_ff[`BIS_B_PINT];
  endproperty
  a_pci_irq_set: assert property (p_pci_irq_set)
    else $error("pci interrupt flag missed");

  property p_pci_parity_set;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (PCI_PARITY_IN && st_ff.enable_ff[`BIS_B_PERR])
    |=> st_ff.flags_ff[`BIS_B_PERR];
  endproperty
  a_pci_parity_set: assert property (p_pci_parity_set)
    else $error("pci parity flag missed");

  property p_pci_syserr_set;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (PCI_SYSERR_IN && st_ff.enable_ff[`BIS_B_SERR])
    |=> st_ff.flags_ff[`BIS_B_SERR];
  endproperty
  a_pci_syserr_set: assert property (p_pci_syserr_set)
    else $error("pci system error flag missed");

  property p_local_irq_set;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (LOCAL_IRQ_IN && st_ff.enable_ff[`BIS_B_QINT])
    |=> st_ff.flags_ff[`BIS_B_QINT];
  endproperty
  a_local_irq_set: assert property (p_local_irq_set)
    else $error("local interrupt flag missed");

  property p_mailbox_set;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (MAILBOX_IN[0] && st_ff.enable_ff[`BIS_B_MB0])
    |=> st_ff.flags_ff[`BIS_B_MB0];
  endproperty
  a_mailbox_set: assert property (p_mailbox_set)
    else $error("mailbox flag missed");

  property p_local_parity_set;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (LOCAL_PARITY_ERR_IN && st_ff.enable_ff[`BIS_B_QDPE])
    |=> st_ff.flags_ff[`BIS_B_QDPE];
  endproperty
  a_local_parity_set: assert property (p_local_parity_set)
    else $error("local parity flag missed");

  property p_new_post_set;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (IN_POST_NEW_IN && st_ff.enable_ff[`BIS_B_IPN])
    |=> st_ff.flags_ff[`BIS_B_IPN];
  endproperty
  a_new_post_set: assert property (p_new_post_set)
    else $error("new post flag missed");

  // ===========================================================
  // Checks on levels, enables, the held source bit and the request
  // Level flags pass one flop, so they are held against last cycle's pin.
  property p_out_post_level;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    1'h1 |=>
      st_ff.flags_ff[`BIS_B_OPNE] == $past(OUT_POST_NONEMPTY_IN);
  endproperty
  a_out_post_level: assert property (p_out_post_level)
    else $error("outbound post level flag out of step");

  property p_in_full_level;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    1'h1 |=>
      st_ff.flags_ff[`BIS_B_IPF] == $past(IN_POST_FULL_IN);
  endproperty
  a_in_full_level: assert property (p_in_full_level)
    else $error("inbound full level flag out of step");

  property p_source_kept;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (wr_stat && WDATA_IN[`BIS_B_MDPED] && st_ff.pcs_prev_ff
     && MASTER_PARITY_SOURCE_BIT_IN)
    |=> !st_ff.flags_ff[`BIS_B_MDPED];
  endproperty
  a_source_kept: assert property (p_source_kept)
    else $error("held source bit set its flag again");

  property p_irq_quiet;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    (((st_ff.flags_ff & `BIS_STICKY_MASK) == `BIS_ZERO)
     && ((en_eff & `BIS_LEVEL_MASK) == `BIS_ZERO))
    |-> !IRQ_OUT;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("request raised with nothing pending");

  property p_enable_mask;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    wr_ctl |=>
      st_ff.enable_ff == ($past(WDATA_IN) & `BIS_CTL_RW_MASK);
  endproperty
  a_enable_mask: assert property (p_enable_mask)
    else $error("enable word wrote wrong bits");

endmodule // bis_interrupt_status

// file: design/bis_pkg.sv
// Types for the bridge interrupt status block.
// Assumes bis_cfg.svh is reachable by bare name.
`include "bis_cfg.svh"
package bis_pkg;
  typedef struct packed {
    logic [31:0] flags_ff;
    logic [31:0] enable_ff;
    logic [31:0] rdata_ff;
    logic pcs_prev_ff;
  } bis_state_type;
endpackage

// file: tb/bis_interrupt_status_bench.sv
// Self-checking bench for the bridge interrupt status block.
// Assumes the design files and bis_cfg.svh are compiled alongside.
`timescale 1ns/1ps
`include "bis_cfg.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  err_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module bis_interrupt_status_bench;
  localparam logic [31:0] BASE = `BIS_STAT_RST;
  localparam logic [31:0] ENS = `BIS_CTL_RW_MASK;
  // Level enables stay off in the loop so each flag alone drives IRQ.
  localparam logic [31:0] ENV = ENS & ~`BIS_LEVEL_MASK;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [31:0] ev = 32'h0;
  logic [31:0] lvl = 32'h00000C00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ope = 1'b0;
  logic [31:0] rdata;
  logic [31:0] en_out;
  logic irq;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  // ==========================================================
  // Device under test
  bis_interrupt_status bis_interrupt_status_inst (
    .CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
    .PCI_ERRLOG_IN(ev[31]), .LOCAL_ERRLOG_IN(ev[30]),
    .MASTER_PARITY_SOURCE_BIT_IN(ev[29]), .PCI_CFG_STATUS_SET_IN(ev[28]),
    .DMA_LOCAL_ERR_IN(ev[27]), .DMA_PCI_ERR_IN(ev[26]),
    .DMA_RESET_IN(ev[25]), .DMA_DONE_IN(ev[24]), .PCI_IRQ_IN(ev[23]),
    .PCI_PARITY_IN(ev[22]), .PCI_SYSERR_IN(ev[21]),
    .LOCAL_IRQ_IN(ev[20]), .MAILBOX_IN(ev[19:16]),
    .LOCAL_PARITY_ERR_IN(ev[15]), .POWER_CHANGE_IN(ev[14]),
    .IN_POST_NEW_IN(ev[12]), .OUT_POST_NONEMPTY_IN(lvl[13]),
    .IN_FREE_EMPTY_IN(lvl[11]), .OUT_FREE_EMPTY_IN(lvl[10]),
    .IN_POST_FULL_IN(lvl[9]), .OUT_FREE_FULL_IN(lvl[8]),
    .OUT_POST_ENABLE_IN(ope), .ENABLE_OUT(en_out), .IRQ_OUT(irq)
  );
  // ==========================================================
  // Clock, watchdog and verdict
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic give_verdict();
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      give_verdict();
    end
  end
  // ==========================================================
  // Register port tasks; event pulses ride along with a write.
  task automatic wr_op(input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] p);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    ev <= p;
    @(posedge clk);
    wr <= 1'b0;
    ev <= 32'h0;
    #1;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
                        input string n);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(n, e, rdata)
  endtask
  // ==========================================================
  // Test sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(`BIS_OFF_STAT, BASE, "stat_rst");
    rd_chk(`BIS_OFF_CTL, 32'h0, "ctl_rst");
    // Unmapped write of all ones must not clear or set anything.
    wr_op(12'h0FC, 32'hFFFFFFFF, 32'hFFFFF000);
    rd_chk(`BIS_OFF_STAT, BASE, "no_enable");
    rd_chk(12'h0FC, 32'h0, "unmapped");
    wr_op(`BIS_OFF_CTL, ENS, 32'h0);
    rd_chk(`BIS_OFF_CTL, ENS, "ctl_rw");
    `CHK("enable_out", ENS, en_out)
    `CHK("irq_lvl", 1'b1, irq)
    wr_op(`BIS_OFF_CTL, ENV, 32'h0);
    for (int i = 0; i < 32; i++) begin
      if (`BIS_STICKY_MASK >> i & 1) begin
        if (i < 4) begin
          wr_op(`BIS_OFF_CTL, ENV | (32'h1 << i), 32'h0);
        end else begin
          wr_op(12'h0FC, 32'h0, 32'h1 << i);
        end
        rd_chk(`BIS_OFF_STAT, BASE | (32'h1 << i), "set");
        `CHK("irq_set", 1'b1, irq)
        wr_op(`BIS_OFF_STAT, ~(32'h1 << i), 32'h0);
        rd_chk(`BIS_OFF_STAT, BASE | (32'h1 << i), "hold");
        wr_op(`BIS_OFF_STAT, 32'h1 << i, 32'h0);
        rd_chk(`BIS_OFF_STAT, BASE, "clear");
        `CHK("irq_clr", 1'b0, irq)
      end
    end
    rd_chk(`BIS_OFF_CTL, ENV, "trig_rd0");
    // A source bit held high must not set its flag again after a clear;
    // dropping it after the write stands for software's own clear.
    @(posedge clk);
    ev <= 32'h20000000;
    rd_chk(`BIS_OFF_STAT, BASE | 32'h20000000, "src_rise");
    wr_op(`BIS_OFF_STAT, 32'h20000000, 32'h20000000);
    rd_chk(`BIS_OFF_STAT, BASE, "src_kept");
    wr_op(12'h0FC, 32'h0, 32'h01000000);
    wr_op(`BIS_OFF_STAT, 32'h01000000, 32'h01000000);
    rd_chk(`BIS_OFF_STAT, BASE | 32'h01000000, "set_wins");
    wr_op(`BIS_OFF_CTL, 32'h0, 32'h0);
    `CHK("irq_masked", 1'b0, irq)
    wr_op(`BIS_OFF_STAT, 32'h01000000, 32'h0);
    // Queue levels flip with every enable off, then resist a clear.
    @(posedge clk);
    lvl <= 32'h00002300;
    repeat (2) @(posedge clk);
    rd_chk(`BIS_OFF_STAT, 32'h00002300, "levels");
    wr_op(`BIS_OFF_STAT, 32'hFFFFFFFF, 32'h0);
    rd_chk(`BIS_OFF_STAT, 32'h00002300, "lvl_ro");
    @(posedge clk);
    ope <= 1'b1;
    repeat (2) @(posedge clk);
    #1 `CHK("ope_bit", 32'h00002000, en_out)
    `CHK("irq_ope", 1'b1, irq)
    rd_chk(`BIS_OFF_CTL, 32'h00002000, "ope_rd");
    give_verdict();
  end
endmodule // bis_interrupt_status_bench
